// file: foccl_regulator.sv
`timescale 1ns/1ps
// Contract
// [R1] Closed loop uses observer angle and speed estimates, never a sensor input.
// [R2] Reference slews linearly, rise rate when rising, fall rate when falling.
// [R3] Speed loop is PI with configurable gains; output is q current reference.
// [R4] Speed loop output is clamped to the phase current cap.
// [R5] Speed loop integral stops accumulating while its output saturates.
// [R6] Speed setpoint is the slewed reference; feedback is estimated speed.
// [R7] Separate d and q current PI loops share one gain pair.
// [R8] Current loops output d/q voltage commands clamped to supply voltage.
// [R9] d-axis loop runs before q-axis; d voltage is checked for saturation.
// [R10] A saturated current loop stops integrating.
// [R11] Mode 01b regulates input DC power, capped at maximum power.
// [R12] Power loop reuses the speed loop gains.
// [R13] Mode 10b sets d/q current references from duty, cap and lead angle.
// [R14] Mode 11b disables loops; d/q voltages from modulation index and lead.
// [R15] Modulation index reference spans minimum duty to full scale.
// [R16] Software must not select recirculation stop in modulation index mode.
// [R17] Overmodulation enable raises fundamental voltage via altered PWM pattern.
// [R18] Speed limit enable holds speed at or below maximum in every mode.
// [R19] Active speed limit uses gentle rate; normal rates return below maximum.
// [R20] Power limit enable caps input power at maximum in every mode.
// [R21] Active power limit uses gentle rate; normal rates return below maximum.
// [R22] Any other mode value regulates speed through the speed loop.
// [R23] Each control period: slew, outer loop, d loop, then q loop.
module foccl_regulator #(
  parameter int CTRL_PERIOD_CYCLES = foccl_pkg::CTRL_PERIOD_CYC
) (
  input  wire logic               SYS_CLK,
  input  wire logic               RSTN,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [7:0]         PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  input  wire logic [14:0]        CMD_REF,
  input  wire foccl_pkg::foccl_obs_t OBS_EST,
  input  wire logic signed [15:0] BUS_POWER,
  input  wire logic signed [15:0] ID_MEAS,
  input  wire logic signed [15:0] IQ_MEAS,
  input  wire logic        [15:0] SUPPLY_V,
  output logic signed [15:0]      VD_CMD,
  output logic signed [15:0]      VQ_CMD,
  output logic        [15:0]      THETA_OUT,
  output logic                    OVERMOD,
  output logic                    CMD_UPDATE,
  output logic                    CFG_ERR
);
  if (CTRL_PERIOD_CYCLES < 4 || CTRL_PERIOD_CYCLES > 65536) begin : g_period_chk
    $error("CTRL_PERIOD_CYCLES out of range");
  end

  // Signed multiply of two Q15 values, result back in Q15
  function automatic logic signed [15:0] qmul(input logic signed [15:0] a,
                                              input logic signed [15:0] b);
    logic signed [31:0] p;
    p = a * b;
    return 16'(p >>> foccl_pkg::FRAC_SHIFT);
  endfunction

  // Symmetric clamp to +/- lim
  function automatic logic signed [15:0] clampv(input logic signed [17:0] x,
                                                input logic [15:0] lim);
    logic signed [17:0] l;
    l = $signed({2'b00, lim});
    if (x > l)
      return 16'(l);
    else if (x < -l)
      return 16'(-l);
    else
      return 16'(x);
  endfunction

  // One PI step; accumulator frozen while the output is clamped
  function automatic foccl_pkg::foccl_pi_t pi_step(
    input logic signed [15:0] sp,
    input logic signed [15:0] fb,
    input logic        [15:0] kp,
    input logic        [15:0] ki,
    input logic        [15:0] lim,
    input logic signed [31:0] acc);
    logic signed [16:0] err;
    logic signed [33:0] pt;
    logic signed [33:0] it;
    logic signed [35:0] sum;
    logic signed [35:0] l;
    foccl_pkg::foccl_pi_t r;
    err = 17'(sp) - 17'(fb);
    pt  = 34'(err) * 34'($signed({1'b0, kp}));
    it  = 34'(err) * 34'($signed({1'b0, ki}));
    sum = 36'(pt >>> foccl_pkg::GAIN_SHIFT) + 36'(acc >>> foccl_pkg::GAIN_SHIFT);
    l   = 36'($signed({1'b0, lim}));
    r.sat = (sum > l) || (sum < -l);
    r.out = (sum > l) ? 16'(l) : (sum < -l) ? 16'(-l) : 16'(sum);
    r.acc = r.sat ? acc : 32'(36'(acc) + 36'(it)); // see [R5] see [R10]
    return r;
  endfunction

  // Software registers
  logic [foccl_pkg::CTRL_W-1:0] ctrl;
  logic [31:0] rate;
  logic [15:0] gentle;
  logic [31:0] ogain;
  logic [31:0] cgain;
  logic [31:0] cap;
  logic [31:0] limit;
  logic [31:0] lead;
  // Regulator state
  foccl_pkg::foccl_state_t state;
  logic [15:0]        tick_cnt;
  logic signed [15:0] ref_slew;
  logic signed [15:0] iq_ref;
  logic signed [15:0] id_ref;
  logic signed [31:0] acc_o;
  logic signed [31:0] acc_d;
  logic signed [31:0] acc_q;
  logic               sat_o;
  logic               sat_d;
  logic               sat_q;
  logic               slim_act;
  logic               plim_act;

  // Field views
  foccl_pkg::foccl_mode_t mode;
  logic [15:0] phase_current_cap;
  logic [15:0] max_power;
  logic [15:0] max_speed;
  logic [15:0] min_duty;
  logic signed [15:0] lead_cos;
  logic signed [15:0] lead_sin;
  assign mode              = foccl_pkg::foccl_mode_t'(ctrl[foccl_pkg::CTRL_MODE_LSB +: 2]);
  assign phase_current_cap = cap[15:0];
  assign max_power         = cap[31:16];
  assign max_speed         = limit[15:0];
  assign min_duty          = limit[31:16];
  assign lead_cos          = $signed(lead[15:0]);
  assign lead_sin          = $signed(lead[31:16]);

  // APB decode
  logic        wr_go;
  logic        setup;
  logic        mapped;
  logic [31:0] rd_mux;
  assign setup = PSEL && !PENABLE;
  assign wr_go = PSEL && PENABLE && PREADY && PWRITE;
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (PADDR)
      foccl_pkg::OFS_CTRL:   rd_mux = 32'(ctrl);
      foccl_pkg::OFS_RATE:   rd_mux = rate;
      foccl_pkg::OFS_GENTLE: rd_mux = {16'h0000, gentle};
      foccl_pkg::OFS_OGAIN:  rd_mux = ogain;
      foccl_pkg::OFS_CGAIN:  rd_mux = cgain;
      foccl_pkg::OFS_CAP:    rd_mux = cap;
      foccl_pkg::OFS_LIMIT:  rd_mux = limit;
      foccl_pkg::OFS_LEAD:   rd_mux = lead;
      foccl_pkg::OFS_STATUS: rd_mux = {24'h00_0000, CFG_ERR, plim_act, slim_act,
                                       sat_q, sat_d, sat_o, state};
      foccl_pkg::OFS_REF:    rd_mux = {16'h0000, ref_slew};
      foccl_pkg::OFS_VOLT:   rd_mux = {VQ_CMD, VD_CMD};
      default:               mapped = 1'b0;
    endcase
  end

  // No wait states: ready and read data settle during the access phase
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup && !mapped;
      if (setup && !PWRITE)
        PRDATA <= mapped ? rd_mux : 32'h0000_0000;
    end
  end

  // Writable registers; status words ignore writes
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl   <= '0;
      rate   <= foccl_pkg::RST_RATE;
      gentle <= foccl_pkg::RST_GENTLE;
      ogain  <= foccl_pkg::RST_GAIN;
      cgain  <= foccl_pkg::RST_GAIN;
      cap    <= foccl_pkg::RST_CAP;
      limit  <= foccl_pkg::RST_LIMIT;
      lead   <= foccl_pkg::RST_LEAD;
    end else if (wr_go) begin
      case (PADDR)
        foccl_pkg::OFS_CTRL:   ctrl   <= PWDATA[foccl_pkg::CTRL_W-1:0];
        foccl_pkg::OFS_RATE:   rate   <= PWDATA;
        foccl_pkg::OFS_GENTLE: gentle <= PWDATA[15:0];
        foccl_pkg::OFS_OGAIN:  ogain  <= PWDATA;
        foccl_pkg::OFS_CGAIN:  cgain  <= PWDATA;
        foccl_pkg::OFS_CAP:    cap    <= PWDATA;
        foccl_pkg::OFS_LIMIT:  limit  <= PWDATA;
        foccl_pkg::OFS_LEAD:   lead   <= PWDATA;
        default:               ;
      endcase
    end
  end

  // Flags a setting the hardware does not support; it is not acted on
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN)
      CFG_ERR <= 1'b0;
    else
      CFG_ERR <= ctrl[foccl_pkg::CTRL_RSTOP] && (mode == foccl_pkg::MODE_VOLT); // see [R16]
  end

  // Control period tick
  logic tick;
  assign tick = (tick_cnt == 16'(CTRL_PERIOD_CYCLES - 1));
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN)
      tick_cnt <= 16'h0000;
    else
      tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
  end

  // Sequencer: outer loop, then d, then q, once per period
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= foccl_pkg::ST_IDLE;
    end else begin
      case (state)
        foccl_pkg::ST_IDLE:  state <= tick ? foccl_pkg::ST_OUTER : foccl_pkg::ST_IDLE; // see [R23]
        foccl_pkg::ST_OUTER: state <= foccl_pkg::ST_DAXIS;
        foccl_pkg::ST_DAXIS: state <= foccl_pkg::ST_QAXIS; // see [R9]
        foccl_pkg::ST_QAXIS: state <= foccl_pkg::ST_IDLE;
        default:             state <= foccl_pkg::ST_IDLE;
      endcase
    end
  end

  // Limit detection on observer speed and measured bus power
  logic signed [15:0] spd_est;
  assign spd_est = OBS_EST.speed; // see [R1]
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      slim_act <= 1'b0;
      plim_act <= 1'b0;
    end else if (tick) begin
      slim_act <= ctrl[foccl_pkg::CTRL_SLIM] && (spd_est >= $signed(max_speed)); // see [R18]
      plim_act <= ctrl[foccl_pkg::CTRL_PLIM] && (BUS_POWER >= $signed(max_power)); // see [R20]
    end
  end

  // Slew target: mode scaling plus limit restriction
  logic signed [15:0] target;
  logic signed [15:0] vspan;
  logic [15:0]        step;
  always_comb begin
    vspan  = 16'(qmul($signed(foccl_pkg::FULL_SCALE - min_duty), $signed({1'b0, CMD_REF})));
    target = $signed({1'b0, CMD_REF});
    if (mode == foccl_pkg::MODE_VOLT)
      target = $signed(min_duty) + vspan; // see [R15]
    if (mode == foccl_pkg::MODE_POWER && target > $signed(max_power))
      target = $signed(max_power); // see [R11]
    if (ctrl[foccl_pkg::CTRL_SLIM] && mode == foccl_pkg::MODE_SPEED
        && target > $signed(max_speed))
      target = $signed(max_speed); // see [R18]
    // Other modes restrict their own quantity by walking it down
    if ((slim_act && mode != foccl_pkg::MODE_SPEED) || (plim_act && mode != foccl_pkg::MODE_POWER))
      target = (ref_slew > 0) ? 16'h0000 : ref_slew; // see [R18] see [R20]
    // Gentle rate avoids chatter around the limit
    if (slim_act || plim_act)
      step = gentle; // see [R19] see [R21]
    else
      step = (target > ref_slew) ? rate[15:0] : rate[31:16]; // see [R2]
  end

  // Linear ramp toward target, never overshooting
  logic signed [16:0] up;
  logic signed [16:0] dn;
  assign up = 17'(ref_slew) + 17'($signed({1'b0, step}));
  assign dn = 17'(ref_slew) - 17'($signed({1'b0, step}));
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN)
      ref_slew <= 16'h0000;
    else if (tick) begin
      if (target > ref_slew)
        ref_slew <= (up > 17'(target)) ? target : 16'(up); // see [R2]
      else if (target < ref_slew)
        ref_slew <= (dn < 17'(target)) ? target : 16'(dn); // see [R2]
    end
  end

  // Outer loop and direct current references
  foccl_pkg::foccl_pi_t outer;
  logic signed [15:0]   outer_fb;
  logic signed [15:0]   imag;
  assign outer_fb = (mode == foccl_pkg::MODE_POWER) ? BUS_POWER : spd_est; // see [R6] see [R11]
  assign outer    = pi_step(ref_slew, outer_fb, ogain[15:0], ogain[31:16],
                            phase_current_cap, acc_o); // see [R3] see [R4] see [R12]
  assign imag     = qmul(ref_slew, $signed(phase_current_cap));
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      acc_o  <= '0;
      sat_o  <= 1'b0;
      iq_ref <= 16'h0000;
      id_ref <= 16'h0000;
    end else if (state == foccl_pkg::ST_OUTER) begin
      case (mode)
        foccl_pkg::MODE_CURRENT: begin
          iq_ref <= qmul(imag, lead_cos); // see [R13]
          id_ref <= -qmul(imag, lead_sin); // see [R13]
          acc_o  <= '0;
          sat_o  <= 1'b0;
        end
        foccl_pkg::MODE_VOLT: begin
          acc_o <= '0; // see [R14]
          sat_o <= 1'b0;
        end
        default: begin
          iq_ref <= outer.out; // see [R3] see [R22]
          id_ref <= 16'h0000;
          acc_o  <= outer.acc; // see [R5]
          sat_o  <= outer.sat;
        end
      endcase
    end
  end

  // Voltage ceiling; overmodulation allows roughly 15 percent more
  logic [16:0] vboost;
  logic [15:0] vlim;
  assign vboost = {1'b0, SUPPLY_V} + (ctrl[foccl_pkg::CTRL_OVM] ?
                  17'(SUPPLY_V >> 3) + 17'(SUPPLY_V >> 5) : 17'h0_0000); // see [R17]
  assign vlim   = (vboost > 17'(foccl_pkg::FULL_SCALE)) ? foccl_pkg::FULL_SCALE
                                                         : vboost[15:0];

  // Current loops share one gain pair
  foccl_pkg::foccl_pi_t dloop;
  foccl_pkg::foccl_pi_t qloop;
  assign dloop = pi_step(id_ref, ID_MEAS, cgain[15:0], cgain[31:16], vlim, acc_d); // see [R7]
  assign qloop = pi_step(iq_ref, IQ_MEAS, cgain[15:0], cgain[31:16], vlim, acc_q); // see [R7]

  // Voltage mode sidesteps the current loops entirely
  logic signed [15:0] vm_d;
  logic signed [15:0] vm_q;
  assign vm_d = clampv(18'(-qmul(ref_slew, lead_sin)), vlim); // see [R14]
  assign vm_q = clampv(18'(qmul(ref_slew, lead_cos)), vlim); // see [R14]

  // d axis first, then q; each output clamped to vlim, the supply raised by overmodulation when enabled
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      VD_CMD <= 16'h0000;
      VQ_CMD <= 16'h0000;
      acc_d  <= '0;
      acc_q  <= '0;
      sat_d  <= 1'b0;
      sat_q  <= 1'b0;
    end else if (mode == foccl_pkg::MODE_VOLT) begin
      if (state == foccl_pkg::ST_DAXIS)
        VD_CMD <= vm_d;
      if (state == foccl_pkg::ST_QAXIS)
        VQ_CMD <= vm_q;
      acc_d <= '0;
      acc_q <= '0;
      sat_d <= 1'b0;
      sat_q <= 1'b0;
    end else if (state == foccl_pkg::ST_DAXIS) begin
      VD_CMD <= dloop.out; // see [R8] see [R9]
      acc_d  <= dloop.acc; // see [R10]
      sat_d  <= dloop.sat; // see [R9]
    end else if (state == foccl_pkg::ST_QAXIS) begin
      VQ_CMD <= qloop.out; // see [R8]
      acc_q  <= qloop.acc; // see [R10]
      sat_q  <= qloop.sat;
    end
  end

  // Angle pass-through, overmodulation flag and update strobe for PWM
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      THETA_OUT  <= 16'h0000;
      OVERMOD    <= 1'b0;
      CMD_UPDATE <= 1'b0;
    end else begin
      THETA_OUT  <= OBS_EST.theta; // see [R1]
      OVERMOD    <= ctrl[foccl_pkg::CTRL_OVM]; // see [R17]
      CMD_UPDATE <= (state == foccl_pkg::ST_QAXIS);
    end
  end
endmodule // foccl_regulator

// file: foccl_pkg.sv
package foccl_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_RATE   = 8'h04;
  localparam logic [7:0] OFS_GENTLE = 8'h08;
  localparam logic [7:0] OFS_OGAIN  = 8'h0C;
  localparam logic [7:0] OFS_CGAIN  = 8'h10;
  localparam logic [7:0] OFS_CAP    = 8'h14;
  localparam logic [7:0] OFS_LIMIT  = 8'h18;
  localparam logic [7:0] OFS_LEAD   = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_REF    = 8'h24;
  localparam logic [7:0] OFS_VOLT   = 8'h28;
  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_OVM      = 2;
  localparam int CTRL_SLIM     = 3;
  localparam int CTRL_PLIM     = 4;
  localparam int CTRL_RSTOP    = 5;
  localparam int CTRL_W        = 6;
  // Reset values
  localparam logic [31:0] RST_RATE   = 32'h0010_0010;
  localparam logic [15:0] RST_GENTLE = 16'h0002;
  localparam logic [31:0] RST_GAIN   = 32'h0010_0100;
  localparam logic [31:0] RST_CAP    = 32'h7FFF_4000;
  localparam logic [31:0] RST_LIMIT  = 32'h0000_7FFF;
  localparam logic [31:0] RST_LEAD   = 32'h0000_7FFF;
  // Fixed-point constants
  localparam logic [15:0] FULL_SCALE = 16'h7FFF;
  localparam int          GAIN_SHIFT = 8;
  localparam int          FRAC_SHIFT = 15;
  // Control period timing
  localparam int CLK_PERIOD_NS   = 5;
  localparam int CTRL_PERIOD_NS  = 50000;
  localparam int CTRL_PERIOD_CYC = CTRL_PERIOD_NS / CLK_PERIOD_NS;
  // Reference modes
  typedef enum logic [1:0] {
    MODE_SPEED   = 2'h0,
    MODE_POWER   = 2'h1,
    MODE_CURRENT = 2'h2,
    MODE_VOLT    = 2'h3
  } foccl_mode_t;
  // Sequencer states, Gray coded along the loop
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_OUTER = 2'b01,
    ST_DAXIS = 2'b11,
    ST_QAXIS = 2'b10
  } foccl_state_t;
  // One PI evaluation result
  typedef struct packed {
    logic signed [15:0] out;
    logic signed [31:0] acc;
    logic               sat;
  } foccl_pi_t;
  // Observer estimates
  typedef struct packed {
    logic signed [15:0] speed;
    logic        [15:0] theta;
  } foccl_obs_t;
endpackage

// file: foccl_assertions.sv
`timescale 1ns/1ps
module foccl_assertions #(
  parameter int CTRL_PERIOD_CYCLES = foccl_pkg::CTRL_PERIOD_CYC
) (
  input wire logic                  SYS_CLK,
  input wire logic                  RSTN,
  input wire logic                  PSEL,
  input wire logic                  PENABLE,
  input wire logic                  PREADY,
  input wire logic                  PSLVERR,
  input wire foccl_pkg::foccl_obs_t OBS_EST,
  input wire logic        [15:0]    SUPPLY_V,
  input wire logic signed [15:0]    VD_CMD,
  input wire logic signed [15:0]    VQ_CMD,
  input wire logic        [15:0]    THETA_OUT,
  input wire logic                  OVERMOD,
  input wire logic                  CMD_UPDATE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  logic        [15:0] gap;
  logic               seen;
  logic        [15:0] theta_in;
  logic signed [16:0] lim;
  // Cycles since the last update pulse, so the period can be checked exactly
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      gap  <= 16'h0000;
      seen <= 1'b0;
    end else begin
      gap  <= CMD_UPDATE ? 16'h0001 : gap + 16'h0001;
      seen <= seen | CMD_UPDATE;
    end
  end
  // Observer angle and the plain clamp bound
  assign theta_in = OBS_EST.theta;
  assign lim      = {1'b0, SUPPLY_V};
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence answer_s;
    PREADY ##1 !PREADY;
  endsequence
  apb_answer_a: assert property (setup_s |=> answer_s)
    else $error("ready missing or longer than one cycle after setup");
  error_ready_a: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
    else $error("error flag outside an access phase");
  theta_copy_a: assert property ($past(RSTN) |-> THETA_OUT == $past(theta_in))
    else $error("angle output is not the observer angle one clock late");
  update_pulse_a: assert property (CMD_UPDATE |=> !CMD_UPDATE)
    else $error("update pulse longer than one cycle");
  vq_update_a: assert property ($changed(VQ_CMD) |-> CMD_UPDATE)
    else $error("q voltage changed without a matching update pulse");
  vd_order_a: assert property ($changed(VD_CMD) |-> ##1 CMD_UPDATE)
    else $error("d voltage not written one step before q voltage");
  period_gap_a: assert property (CMD_UPDATE && seen |-> gap == CTRL_PERIOD_CYCLES)
    else $error("update spacing differs from the control period");
  vq_clamp_a: assert property (CMD_UPDATE && !OVERMOD && !$past(OVERMOD)
    |-> VQ_CMD <= lim && VQ_CMD >= -lim)
    else $error("q voltage outside supply");
  vd_clamp_a: assert property (CMD_UPDATE && !OVERMOD && !$past(OVERMOD)
    |-> VD_CMD <= lim && VD_CMD >= -lim)
    else $error("d voltage outside supply");
endmodule // foccl_assertions

bind foccl_regulator foccl_assertions #(.CTRL_PERIOD_CYCLES(CTRL_PERIOD_CYCLES)) u_chk (
  .SYS_CLK, .RSTN, .PSEL, .PENABLE, .PREADY, .PSLVERR, .OBS_EST, .SUPPLY_V,
  .VD_CMD, .VQ_CMD, .THETA_OUT, .OVERMOD, .CMD_UPDATE
);

// file: foccl_motor_model.sv
`timescale 1ns/1ps
// Behavioural motor behind the power stage; the bench sets speed and power
module foccl_motor_model #(
  parameter logic [15:0] SUPPLY = 16'h4000
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic signed [15:0]    vd,
  input wire logic signed [15:0]    vq,
  input wire logic                  upd,
  input wire logic signed [15:0]    speed_set,
  input wire logic signed [15:0]    power_set,
  output foccl_pkg::foccl_obs_t     obs,
  output logic signed [15:0]        power,
  output logic signed [15:0]        id_meas,
  output logic signed [15:0]        iq_meas,
  output logic        [15:0]        supply
);
  logic [15:0] theta;
  // Angle advances by the set speed every clock, so it stands still at zero speed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      theta <= 16'h0000;
    end else begin
      theta <= theta + speed_set;
    end
  end
  // Winding current follows half the applied voltage one period late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      id_meas <= 16'sh0000;
      iq_meas <= 16'sh0000;
    end else if (upd) begin
      id_meas <= vd >>> 1;
      iq_meas <= vq >>> 1;
    end
  end
  // Estimates and supply as seen by the regulator
  assign obs    = {speed_set, theta};
  assign power  = power_set;
  assign supply = SUPPLY;
endmodule // foccl_motor_model

// file: foccl_regulator_test.sv
`timescale 1ns/1ps
module foccl_regulator_test;
  localparam int PER = 8;
  logic                  sys_clk = 1'b0;
  logic                  rstn = 1'b0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0000_0000;
  logic [14:0]           cmd_ref = 15'h0000;
  logic signed [15:0]    spd_set = 16'sh0000;
  logic signed [15:0]    pwr_set = 16'sh0000;
  logic [31:0]           prdata, rd, r1, r2;
  logic                  pready, pslverr, ovm, upd, cfg_err, e;
  logic signed [15:0]    vd, vq, id_m, iq_m, pwr;
  logic [15:0]           supply, theta;
  foccl_pkg::foccl_obs_t obs;
  int                    err_total = 0;
  int                    n_checks = 0;

  // Clock at 200 MHz
  always #2.5 sys_clk = ~sys_clk;

  foccl_regulator #(.CTRL_PERIOD_CYCLES(PER)) dut (
    .SYS_CLK(sys_clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CMD_REF(cmd_ref), .OBS_EST(obs), .BUS_POWER(pwr), .ID_MEAS(id_m), .IQ_MEAS(iq_m),
    .SUPPLY_V(supply), .VD_CMD(vd), .VQ_CMD(vq), .THETA_OUT(theta), .OVERMOD(ovm),
    .CMD_UPDATE(upd), .CFG_ERR(cfg_err));

  foccl_motor_model u_motor (
    .clk(sys_clk), .rst_n(rstn), .vd(vd), .vq(vq), .upd(upd), .speed_set(spd_set),
    .power_set(pwr_set), .obs(obs), .power(pwr), .id_meas(id_m), .iq_meas(iq_m),
    .supply(supply));

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Setup then access; held until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, e);
  endtask

  // Waits for k update pulses; a silent loop is left to the watchdog
  task automatic wait_upd(input int k);
    repeat (k)
      do @(posedge sys_clk); while (upd !== 1'b1);
  endtask

  task automatic reset_regs();
    logic [7:0]  ofs [8] = '{foccl_pkg::OFS_CTRL, foccl_pkg::OFS_RATE, foccl_pkg::OFS_GENTLE,
      foccl_pkg::OFS_OGAIN, foccl_pkg::OFS_CGAIN, foccl_pkg::OFS_CAP, foccl_pkg::OFS_LIMIT,
      foccl_pkg::OFS_LEAD};
    logic [31:0] exp [8] = '{32'h0000_0000, foccl_pkg::RST_RATE, {16'h0000,
      foccl_pkg::RST_GENTLE}, foccl_pkg::RST_GAIN, foccl_pkg::RST_GAIN, foccl_pkg::RST_CAP,
      foccl_pkg::RST_LIMIT, foccl_pkg::RST_LEAD};
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ofs[i], 32'h0000_0000, rd, e);
      check(rd ^ 32'(e), exp[i], "reset value");
    end
    apb(1'b0, 8'h2C, 32'h0000_0000, rd, e);
    check({rd[31:1], rd[0] | !e}, 32'h0000_0000, "unmapped read");
    wr(foccl_pkg::OFS_REF, 32'h0000_1234);
    apb(1'b0, foccl_pkg::OFS_REF, 32'h0000_0000, rd, e);
    check(rd, 32'h0000_0000, "read-only ref");
  endtask

  // Step up then down; rise and fall rates differ so a swap shows
  task automatic ref_ramp();
    wr(foccl_pkg::OFS_RATE, 32'h0200_0100);
    wait_upd(1);
    cmd_ref <= 15'h0350;
    for (int k = 1; k <= 5; k++) begin
      wait_upd(1);
      apb(1'b0, foccl_pkg::OFS_REF, 32'h0000_0000, rd, e);
      check(rd[15:0], (k < 4) ? k * 16'h0100 : 16'h0350, "rising ref");
    end
    cmd_ref <= 15'h0080;
    for (int k = 1; k <= 3; k++) begin
      wait_upd(1);
      apb(1'b0, foccl_pkg::OFS_REF, 32'h0000_0000, rd, e);
      check(rd[15:0], (k == 1) ? 16'h0150 : 16'h0080, "falling ref");
    end
    wr(foccl_pkg::OFS_CAP, 32'h7FFF_0001);
    wait_upd(2);
    apb(1'b0, foccl_pkg::OFS_STATUS, 32'h0000_0000, rd, e);
    check(rd[2], 1'b1, "outer loop held at cap");
  endtask

  // Voltage mode: clamp, overmodulation, bad combination flag, minimum duty
  task automatic volt_mode();
    wr(foccl_pkg::OFS_LIMIT, 32'h1000_7FFF);
    wr(foccl_pkg::OFS_RATE, 32'h7FFF_7FFF);
    cmd_ref <= 15'h7FFF;
    wr(foccl_pkg::OFS_CTRL, 32'h0000_0003);
    wait_upd(2);
    check({vq, vd}, 32'h4000_0000, "voltage mode clamp");
    apb(1'b0, foccl_pkg::OFS_VOLT, 32'h0000_0000, rd, e);
    check(rd, 32'h4000_0000, "voltage readback");
    wr(foccl_pkg::OFS_CTRL, 32'h0000_0007);
    wait_upd(2);
    check({ovm, vq}, {1'b1, 16'h4A00}, "overmodulated clamp");
    wr(foccl_pkg::OFS_CTRL, 32'h0000_0023);
    cmd_ref <= 15'h0000;
    wait_upd(2);
    check({cfg_err, ovm}, 2'b10, "flagged combination");
    check(vq >= 16'sh0FF0 && vq <= 16'sh1000, 1, "minimum duty floor");
    wr(foccl_pkg::OFS_CTRL, 32'h0000_0000);
    wait_upd(1);
    check(cfg_err, 1'b0, "flag cleared");
  endtask

  // Over the limit the ref falls at the gentle rate, then rises at the normal one
  task automatic limit_case(input logic [31:0] ctrl, input logic sp, input int bitn);
    wr(foccl_pkg::OFS_RATE, 32'h7FFF_7FFF);
    wr(foccl_pkg::OFS_CAP, 32'h1000_4000);
    wr(foccl_pkg::OFS_LIMIT, 32'h0000_1000);
    wr(foccl_pkg::OFS_GENTLE, 32'h0000_0010);
    cmd_ref <= 15'h0400;
    wr(foccl_pkg::OFS_CTRL, ctrl);
    wait_upd(2);
    wr(foccl_pkg::OFS_RATE, 32'h0100_0100);
    cmd_ref <= 15'h7FFF;
    for (int p = 0; p < 2; p++) begin
      spd_set <= (sp && p == 0) ? 16'sh2000 : 16'sh0000;
      pwr_set <= (!sp && p == 0) ? 16'sh2000 : 16'sh0000;
      wait_upd(2);
      apb(1'b0, foccl_pkg::OFS_REF, 32'h0000_0000, r1, e);
      wait_upd(1);
      apb(1'b0, foccl_pkg::OFS_REF, 32'h0000_0000, r2, e);
      check(16'(r2 - r1), (p == 0) ? 16'hFFF0 : 16'h0100, "limit ramp");
      apb(1'b0, foccl_pkg::OFS_STATUS, 32'h0000_0000, rd, e);
      check(rd[bitn], p == 0, "limit active flag");
    end
  endtask

  task automatic stop_test();
    if (err_total == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    reset_regs();
    ref_ramp();
    volt_mode();
    limit_case(32'h0000_000A, 1'b1, 5);
    limit_case(32'h0000_0010, 1'b0, 6);
    stop_test();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    stop_test();
  end
endmodule // foccl_regulator_test
